/* hdl/link_cfg_pkg.sv */
// Function
// - Single link modes 0-10, dual link 4-10
// - Control bit 3 selects dual-link operation
// - Host programs second link identical to first
// - Page bit 2 steers writes to second link
// - Sync power bit 0 powers down second sync
// - Check bit 5 flags illegal clock delay
// - Check bit 3 flags unsupported L/M/F/S
// - Check bit 2 flags illegal K
// - Check bit 1 flags illegal subclass version
// - Deskew mask bit per used lane
// - Lane enable mask bit per used lane
// - Lane register: scramble bit 7, L-1 below
// - Host writes F-1 and F both
// - K-1 field: 0x0f or 0x1f; F=1 needs 32
// - Converter register holds M-1
// - Subclass field 0 or 1, NP-1 0xf
// - Version field 1, S-1 below
// - Masks 0xff for eight lanes, 0x0f four
// - Version 0 is older, 1 is current
package link_cfg_pkg;

    localparam logic [11:0] ADDR_CHECK     = 12'h030;
    localparam logic [11:0] ADDR_SYNC_PWR  = 12'h203;
    localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
    localparam logic [11:0] ADDR_MFC_DELAY = 12'h304;
    localparam logic [11:0] ADDR_LANE_CNT  = 12'h453;
    localparam logic [11:0] ADDR_F_M1      = 12'h454;
    localparam logic [11:0] ADDR_K_M1      = 12'h455;
    localparam logic [11:0] ADDR_M_M1      = 12'h456;
    localparam logic [11:0] ADDR_RES       = 12'h457;
    localparam logic [11:0] ADDR_SUBCLASS  = 12'h458;
    localparam logic [11:0] ADDR_VERSION   = 12'h459;
    localparam logic [11:0] ADDR_DENSITY   = 12'h45a;
    localparam logic [11:0] ADDR_DESKEW    = 12'h46c;
    localparam logic [11:0] ADDR_F_FULL    = 12'h476;
    localparam logic [11:0] ADDR_LANE_EN   = 12'h47d;

    localparam int          NUM_PAR      = 11;
    localparam logic [3:0]  IDX_LANE_CNT = 4'h0;
    localparam logic [3:0]  IDX_F_M1     = 4'h1;
    localparam logic [3:0]  IDX_K_M1     = 4'h2;
    localparam logic [3:0]  IDX_M_M1     = 4'h3;
    localparam logic [3:0]  IDX_RES      = 4'h4;
    localparam logic [3:0]  IDX_SUBCLASS = 4'h5;
    localparam logic [3:0]  IDX_VERSION  = 4'h6;
    localparam logic [3:0]  IDX_DENSITY  = 4'h7;
    localparam logic [3:0]  IDX_DESKEW   = 4'h8;
    localparam logic [3:0]  IDX_F_FULL   = 4'h9;
    localparam logic [3:0]  IDX_LANE_EN  = 4'ha;

    localparam int          DUAL_BIT    = 3;
    localparam int          PAGE_BIT    = 2;
    localparam int          SYNC_PD_BIT = 0;
    localparam int          CHK_MFC     = 5;
    localparam int          CHK_LMFS    = 3;
    localparam int          CHK_K       = 2;
    localparam int          CHK_SUBV    = 1;
    localparam int          SCR_BIT     = 7;
    localparam int          HD_BIT      = 7;
    localparam int          TOP_LSB     = 5;

    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam logic [4:0]  K16_M1       = 5'h0f;
    localparam logic [4:0]  K32_M1       = 5'h1f;
    localparam logic [2:0]  VER_A        = 3'h0;
    localparam logic [2:0]  VER_B        = 3'h1;
    localparam logic [2:0]  SUBCLASS_0   = 3'h0;
    localparam logic [2:0]  SUBCLASS_1   = 3'h1;
    localparam logic [4:0]  NP_M1        = 5'h0f;
    localparam logic [7:0]  RES_VAL      = 8'h0f;
    localparam logic [3:0]  MAX_MODE     = 4'ha;
    localparam logic [3:0]  DUAL_MIN     = 4'h4;

    typedef struct packed {
        logic       valid;
        logic [3:0] l;
        logic [3:0] m;
        logic [3:0] f;
        logic [3:0] s;
        logic       hd;
    } mode_row_t;

    // Supported operating modes; mode 8 does not exist
    function automatic mode_row_t mode_row(input logic [3:0] mode);
        case (mode)
            4'h0:    mode_row = '{1'b1, 4'h8, 4'h4, 4'h1, 4'h1, 1'b1};
            4'h1:    mode_row = '{1'b1, 4'h8, 4'h4, 4'h2, 4'h2, 1'b0};
            4'h2:    mode_row = '{1'b1, 4'h4, 4'h4, 4'h2, 4'h1, 1'b0};
            4'h3:    mode_row = '{1'b1, 4'h2, 4'h4, 4'h4, 4'h1, 1'b0};
            4'h4:    mode_row = '{1'b1, 4'h4, 4'h2, 4'h1, 4'h1, 1'b1};
            4'h5:    mode_row = '{1'b1, 4'h4, 4'h2, 4'h2, 4'h2, 1'b0};
            4'h6:    mode_row = '{1'b1, 4'h2, 4'h2, 4'h2, 4'h1, 1'b0};
            4'h7:    mode_row = '{1'b1, 4'h1, 4'h2, 4'h4, 4'h1, 1'b0};
            4'h9:    mode_row = '{1'b1, 4'h2, 4'h1, 4'h1, 4'h1, 1'b1};
            4'ha:    mode_row = '{1'b1, 4'h1, 4'h1, 4'h2, 4'h1, 1'b0};
            default: mode_row = '{1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0};
        endcase
    endfunction

    function automatic logic [11:0] par_addr(input logic [3:0] idx);
        case (idx)
            IDX_LANE_CNT: par_addr = ADDR_LANE_CNT;
            IDX_F_M1:     par_addr = ADDR_F_M1;
            IDX_K_M1:     par_addr = ADDR_K_M1;
            IDX_M_M1:     par_addr = ADDR_M_M1;
            IDX_RES:      par_addr = ADDR_RES;
            IDX_SUBCLASS: par_addr = ADDR_SUBCLASS;
            IDX_VERSION:  par_addr = ADDR_VERSION;
            IDX_DENSITY:  par_addr = ADDR_DENSITY;
            IDX_DESKEW:   par_addr = ADDR_DESKEW;
            IDX_F_FULL:   par_addr = ADDR_F_FULL;
            default:      par_addr = ADDR_LANE_EN;
        endcase
    endfunction

endpackage

/* hdl/link_cfg_if.sv */
`timescale 1ns/1ps
interface link_cfg_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;

    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* hdl/link_cfg_regs.sv */
`timescale 1ns/1ps
module link_cfg_regs
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    link_cfg_if.device       bus,
    output logic             dual_link,
    output logic             second_sync_pd,
    output logic             descramble_en,
    output logic             subclass_one,
    output logic             version_b,
    output logic [15:0]      deskew_mask,
    output logic [15:0]      lane_enable_mask,
    output logic [7:0]       config_flags
);

    typedef struct packed {
        logic [1:0][10:0][7:0] par;
        logic [7:0]            ctrl;
        logic [7:0]            sync_pwr;
        logic [7:0]            mfc_delay;
        logic [7:0]            rdata;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic [7:0] flags;

    // Map an address onto a parameter index; hit low when none matches
    function automatic logic [4:0] par_lookup(input logic [11:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < link_cfg_pkg::NUM_PAR; i++)
        begin
            if (a == link_cfg_pkg::par_addr(4'(i)))
            begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Parameter set against the supported modes
    function automatic logic lmfs_ok(input logic [10:0][7:0] p, input logic dual);
        link_cfg_pkg::mode_row_t row;
        logic                    ok;
        ok = 1'b0;
        for (int m = 0; m <= link_cfg_pkg::MAX_MODE; m++)
        begin
            row = link_cfg_pkg::mode_row(4'(m));
            if (row.valid && (!dual || 4'(m) >= link_cfg_pkg::DUAL_MIN)
                && {1'b0, row.l} == p[link_cfg_pkg::IDX_LANE_CNT][4:0] + 5'h01
                && {4'h0, row.m} == p[link_cfg_pkg::IDX_M_M1] + 8'h01
                && {4'h0, row.f} == p[link_cfg_pkg::IDX_F_M1] + 8'h01
                && {1'b0, row.s} == p[link_cfg_pkg::IDX_VERSION][4:0] + 5'h01)
            begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    logic                  page;
    logic [10:0][7:0]      cur;
    logic [4:0]            wr_hit;
    logic [4:0]            rd_hit;
    logic [4:0]            k_m1;

    always_comb
    begin
        page   = q.ctrl[link_cfg_pkg::PAGE_BIT];
        cur    = q.par[page];
        k_m1   = cur[link_cfg_pkg::IDX_K_M1][4:0];
        wr_hit = par_lookup(bus.addr);
        rd_hit = par_lookup(bus.addr);
        flags  = 8'h00;
        // Checks are pure decode of the held settings of the paged link
        flags[link_cfg_pkg::CHK_MFC]  = q.mfc_delay > {3'h0, k_m1};
        flags[link_cfg_pkg::CHK_LMFS] = !lmfs_ok(cur, q.ctrl[link_cfg_pkg::DUAL_BIT]);
        flags[link_cfg_pkg::CHK_K]    = !((k_m1 == link_cfg_pkg::K32_M1)
            || (k_m1 == link_cfg_pkg::K16_M1 && cur[link_cfg_pkg::IDX_F_M1] != 8'h00));
        flags[link_cfg_pkg::CHK_SUBV] = cur[link_cfg_pkg::IDX_SUBCLASS][7:5]
            > link_cfg_pkg::SUBCLASS_1;

        d = q;
        if (bus.wr)
        begin
            if (bus.addr == link_cfg_pkg::ADDR_LINK_CTRL)
            begin
                d.ctrl = bus.wdata & 8'h0c;
            end
            else if (bus.addr == link_cfg_pkg::ADDR_SYNC_PWR)
            begin
                d.sync_pwr = bus.wdata & 8'h01;
            end
            else if (bus.addr == link_cfg_pkg::ADDR_MFC_DELAY)
            begin
                d.mfc_delay = bus.wdata;
            end
            else if (wr_hit[4])
            begin
                d.par[page][wr_hit[3:0]] = bus.wdata;
            end
        end

        d.rdata = 8'h00;
        if (bus.rd)
        begin
            if (bus.addr == link_cfg_pkg::ADDR_CHECK)
            begin
                d.rdata = flags;
            end
            else if (bus.addr == link_cfg_pkg::ADDR_LINK_CTRL)
            begin
                d.rdata = q.ctrl;
            end
            else if (bus.addr == link_cfg_pkg::ADDR_SYNC_PWR)
            begin
                d.rdata = q.sync_pwr;
            end
            else if (bus.addr == link_cfg_pkg::ADDR_MFC_DELAY)
            begin
                d.rdata = q.mfc_delay;
            end
            else if (rd_hit[4])
            begin
                d.rdata = cur[rd_hit[3:0]];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.rdata      = q.rdata;
    assign config_flags   = flags;
    assign dual_link      = q.ctrl[link_cfg_pkg::DUAL_BIT];
    assign second_sync_pd = q.sync_pwr[link_cfg_pkg::SYNC_PD_BIT];
    assign descramble_en  = q.par[0][link_cfg_pkg::IDX_LANE_CNT][link_cfg_pkg::SCR_BIT];
    assign subclass_one   = q.par[0][link_cfg_pkg::IDX_SUBCLASS][7:link_cfg_pkg::TOP_LSB]
                            == link_cfg_pkg::SUBCLASS_1;
    assign version_b      = q.par[0][link_cfg_pkg::IDX_VERSION][7:link_cfg_pkg::TOP_LSB]
                            == link_cfg_pkg::VER_B;
    // Upper byte is the second link; it captures whenever page is set, but reads as zero unless in dual-link operation
    assign deskew_mask    = {q.par[1][link_cfg_pkg::IDX_DESKEW] & {8{dual_link}},
                             q.par[0][link_cfg_pkg::IDX_DESKEW]};
    assign lane_enable_mask = {q.par[1][link_cfg_pkg::IDX_LANE_EN] & {8{dual_link}},
                               q.par[0][link_cfg_pkg::IDX_LANE_EN]};

endmodule

/* hdl/link_cfg_host.sv */
`timescale 1ns/1ps
module link_cfg_host
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    link_cfg_if.host         bus,
    input  wire logic        start,
    input  wire logic [3:0]  mode,
    input  wire logic        dual_req,
    input  wire logic        scramble,
    input  wire logic        subclass1,
    input  wire logic        k32,
    output logic             busy,
    output logic             done,
    output logic             cfg_error,
    output logic [7:0]       cfg_flags
);

    typedef enum logic [1:0] {IDLE, WRITE, READ, WAIT} phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [4:0]  step;
        logic [3:0]  mode;
        logic        dual;
        logic        scr;
        logic        sub1;
        logic        k32;
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        done;
        logic        err;
        logic [7:0]  flags;
    } host_state_t;

    localparam logic [4:0] STEP_PAGE1 = 5'd13;
    localparam logic [4:0] STEP_LAST  = 5'd25;

    host_state_t q;
    host_state_t d;

    function automatic logic [7:0] par_value(input logic [3:0] idx, input host_state_t s);
        link_cfg_pkg::mode_row_t row;
        logic [7:0]              lmask;
        row   = link_cfg_pkg::mode_row(s.mode);
        lmask = 8'((9'h001 << row.l) - 9'h001);
        case (idx)
            link_cfg_pkg::IDX_LANE_CNT: par_value = {s.scr, 2'h0, 5'(row.l - 4'h1)};
            link_cfg_pkg::IDX_F_M1:     par_value = {4'h0, row.f} - 8'h01;
            link_cfg_pkg::IDX_K_M1:     par_value = {3'h0, (s.k32 || row.f == 4'h1)
                                            ? link_cfg_pkg::K32_M1 : link_cfg_pkg::K16_M1};
            link_cfg_pkg::IDX_M_M1:     par_value = {4'h0, row.m - 4'h1};
            link_cfg_pkg::IDX_RES:      par_value = link_cfg_pkg::RES_VAL;
            link_cfg_pkg::IDX_SUBCLASS: par_value = {s.sub1 ? link_cfg_pkg::SUBCLASS_1
                                            : link_cfg_pkg::SUBCLASS_0, link_cfg_pkg::NP_M1};
            link_cfg_pkg::IDX_VERSION:  par_value = {link_cfg_pkg::VER_B, 5'(row.s - 4'h1)};
            link_cfg_pkg::IDX_DENSITY:  par_value = {row.hd, 7'h00};
            link_cfg_pkg::IDX_DESKEW:   par_value = lmask;
            link_cfg_pkg::IDX_F_FULL:   par_value = {4'h0, row.f};
            default:                    par_value = lmask;
        endcase
    endfunction

    // Sequence: control, sync power, link 0 set, page 1 and link 1 set (dual only), page 0
    function automatic logic [19:0] step_op(input host_state_t s);
        logic [7:0] ctl;
        ctl = 8'h00;
        ctl[link_cfg_pkg::DUAL_BIT] = s.dual;
        if (s.step == 5'd0 || s.step == STEP_LAST)
            return {link_cfg_pkg::ADDR_LINK_CTRL, ctl};
        if (s.step == 5'd1)
            return {link_cfg_pkg::ADDR_SYNC_PWR, {7'h00, !s.dual}};
        if (s.step == STEP_PAGE1)
        begin
            ctl[link_cfg_pkg::PAGE_BIT] = 1'b1;
            return {link_cfg_pkg::ADDR_LINK_CTRL, ctl};
        end
        if (s.step < STEP_PAGE1)
            return {link_cfg_pkg::par_addr(4'(s.step - 5'd2)),
                    par_value(4'(s.step - 5'd2), s)};
        return {link_cfg_pkg::par_addr(4'(s.step - 5'd14)), par_value(4'(s.step - 5'd14), s)};
    endfunction

    logic [19:0] op;

    always_comb
    begin
        d      = q;
        d.wr   = 1'b0;
        d.rd   = 1'b0;
        d.done = 1'b0;
        op     = step_op(q);
        case (q.phase)
            IDLE:
            begin
                if (start)
                begin
                    d.phase = WRITE;
                    d.step  = 5'd0;
                    d.mode  = mode;
                    d.dual  = dual_req;
                    d.scr   = scramble;
                    d.sub1  = subclass1;
                    d.k32   = k32;
                end
            end
            WRITE:
            begin
                d.addr  = op[19:8];
                d.wdata = op[7:0];
                d.wr    = 1'b1;
                if (q.step == STEP_LAST)
                begin
                    d.phase = READ;
                end
                else if (q.step == STEP_PAGE1 - 5'd1 && !q.dual)
                begin
                    d.step = STEP_LAST;
                end
                else
                begin
                    d.step = q.step + 5'd1;
                end
            end
            READ:
            begin
                d.addr  = link_cfg_pkg::ADDR_CHECK;
                d.rd    = 1'b1;
                d.phase = WAIT;
            end
            WAIT:
            begin
                if (!q.rd)
                begin
                    d.flags = bus.rdata;
                    d.err   = bus.rdata != 8'h00;
                    d.done  = 1'b1;
                    d.phase = IDLE;
                end
            end
            default:
            begin
                d.phase = IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.addr  = q.addr;
    assign bus.wdata = q.wdata;
    assign bus.wr    = q.wr;
    assign bus.rd    = q.rd;
    assign busy      = q.phase != IDLE;
    assign done      = q.done;
    assign cfg_error = q.err;
    assign cfg_flags = q.flags;

endmodule

/* test/link_cfg_properties.sv */
`timescale 1ns/1ps
module link_cfg_checker
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata
);
    logic [7:0] ctrl_q;

    // Last value written to the link control register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= 8'h00;
        end
        else if (wr && addr == link_cfg_pkg::ADDR_LINK_CTRL)
        begin
            ctrl_q <= wdata;
        end
    end

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_SYNC_PD_SINGLE: assert property (wr && addr == link_cfg_pkg::ADDR_SYNC_PWR
        |-> wdata[link_cfg_pkg::SYNC_PD_BIT] == !ctrl_q[link_cfg_pkg::DUAL_BIT])
        else $error("sync power bit does not follow link mode");
    AST_CHECK_AFTER_CTRL: assert property (rd && addr == link_cfg_pkg::ADDR_CHECK
        |-> $past(wr) && $past(addr) == link_cfg_pkg::ADDR_LINK_CTRL)
        else $error("flag read not preceded by control write");
    AST_F_TWO_PLACES: assert property (wr && addr == link_cfg_pkg::ADDR_F_M1
        |-> ##8 (wr && addr == link_cfg_pkg::ADDR_F_FULL && wdata == $past(wdata, 8) + 8'h01))
        else $error("full octet count does not match minus-one value");
    AST_K_LEGAL: assert property (wr && addr == link_cfg_pkg::ADDR_K_M1
        |-> wdata[4:0] == link_cfg_pkg::K16_M1 || wdata[4:0] == link_cfg_pkg::K32_M1)
        else $error("multiframe length not 16 or 32");
    AST_K32_ONE_OCTET: assert property (wr && addr == link_cfg_pkg::ADDR_K_M1
        && $past(wr) && $past(addr) == link_cfg_pkg::ADDR_F_M1 && $past(wdata) == 8'h00
        |-> wdata[4:0] == link_cfg_pkg::K32_M1)
        else $error("one octet per frame without 32 frames");
    AST_RESOLUTION: assert property (wr && addr == link_cfg_pkg::ADDR_RES
        |-> wdata == link_cfg_pkg::RES_VAL)
        else $error("resolution register value wrong");
    AST_SUBCLASS: assert property (wr && addr == link_cfg_pkg::ADDR_SUBCLASS
        |-> wdata[4:0] == link_cfg_pkg::NP_M1 && wdata[7:5] <= link_cfg_pkg::SUBCLASS_1)
        else $error("subclass register value wrong");
    AST_VERSION: assert property (wr && addr == link_cfg_pkg::ADDR_VERSION
        |-> wdata[7:5] == link_cfg_pkg::VER_B)
        else $error("version field not current");
    AST_DENSITY: assert property (wr && addr == link_cfg_pkg::ADDR_DENSITY
        |-> wdata == (($past(wdata, 6) == 8'h00) ? 8'h80 : 8'h00))
        else $error("density bit does not follow octet count");
    AST_MASKS_EQUAL: assert property (wr && addr == link_cfg_pkg::ADDR_DESKEW
        |-> ##2 (wr && addr == link_cfg_pkg::ADDR_LANE_EN && wdata == $past(wdata, 2)))
        else $error("lane enable mask differs from deskew mask");

    COV_FLAGS_SET: cover property ($past(rd) && rdata != 8'h00);
endmodule

/* test/serial_rx_link_config_bench.sv */
`timescale 1ns/1ps
module serial_rx_link_config_bench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic [3:0]  mode = 4'h0;
    logic        dual_req = 1'b0;
    logic        scramble = 1'b0;
    logic        subclass1 = 1'b0;
    logic        k32 = 1'b0;
    logic        busy, done, cfg_error;
    logic [7:0]  cfg_flags, flg_a, flg_b;
    logic        dual_a, pd_a, scr_a, sub_a, ver_a, dual_b, pd_b, scr_b, sub_b, ver_b;
    logic [15:0] dsk_a, len_a, dsk_b, len_b;
    logic [15:0] seed_q = 16'h86c8;
    logic [11:0] rv_addr [15] = '{12'h030, 12'h203, 12'h300, 12'h304, 12'h453, 12'h454,
        12'h455, 12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h46c, 12'h476, 12'h47d};
    int          err_count = 0;
    int          checks_done = 0;

    link_cfg_if bus_a ();
    link_cfg_if bus_b ();

    always #20 core_clk = ~core_clk;

    link_cfg_regs link_cfg_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_a),
        .dual_link(dual_a), .second_sync_pd(pd_a), .descramble_en(scr_a), .subclass_one(sub_a),
        .version_b(ver_a), .deskew_mask(dsk_a), .lane_enable_mask(len_a), .config_flags(flg_a));
    link_cfg_host link_cfg_host_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_a),
        .start(start), .mode(mode), .dual_req(dual_req), .scramble(scramble),
        .subclass1(subclass1), .k32(k32), .busy(busy), .done(done), .cfg_error(cfg_error),
        .cfg_flags(cfg_flags));
    link_cfg_regs link_cfg_regs_inst_b (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_b),
        .dual_link(dual_b), .second_sync_pd(pd_b), .descramble_en(scr_b), .subclass_one(sub_b),
        .version_b(ver_b), .deskew_mask(dsk_b), .lane_enable_mask(len_b), .config_flags(flg_b));
    link_cfg_checker link_cfg_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
        .addr(bus_a.addr), .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd),
        .rdata(bus_a.rdata));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Lane count of each supported mode, zero where the mode does not exist
    function automatic logic [3:0] l_of(input logic [3:0] m);
        case (m)
            4'h0, 4'h1:       l_of = 4'h8;
            4'h2, 4'h4, 4'h5: l_of = 4'h4;
            4'h3, 4'h6, 4'h9: l_of = 4'h2;
            4'h7, 4'ha:       l_of = 4'h1;
            default:          l_of = 4'h0;
        endcase
    endfunction

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bw(input logic [11:0] a, input logic [7:0] d);
        bus_b.addr  <= a;
        bus_b.wdata <= d;
        bus_b.wr    <= 1'b1;
        bus_b.rd    <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic br(input logic [11:0] a, input logic [7:0] e);
        bus_b.addr <= a;
        bus_b.wr   <= 1'b0;
        bus_b.rd   <= 1'b1;
        @(posedge core_clk);
        bus_b.rd <= 1'b0;
        @(negedge core_clk);
        check(bus_b.rdata, e);
        @(posedge core_clk);
    endtask

    task automatic run(input logic [3:0] m, input logic dl);
        logic [7:0] mk;
        logic       bad;
        int         n;
        seed_q = lfsr_next(seed_q);
        mode <= m;
        dual_req <= dl;
        scramble <= seed_q[0];
        subclass1 <= seed_q[1];
        k32 <= seed_q[2];
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        check(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(done, 1'b1);
        check(busy, 1'b0);
        bad = (l_of(m) == 4'h0) || (dl && m < 4'h4);
        check(cfg_flags[3], bad);
        check(cfg_error, bad);
        check(flg_a[3], bad);
        if (!bad)
        begin
            mk = (8'h01 << l_of(m)) - 8'h01;
            check(cfg_flags, 8'h00);
            check(flg_a, 8'h00);
            check(dsk_a, {dl ? mk : 8'h00, mk});
            check(len_a, {dl ? mk : 8'h00, mk});
            check(dual_a, dl);
            check(pd_a, !dl);
            check(scr_a, seed_q[0]);
            check(sub_a, seed_q[1]);
            check(ver_a, 1'b1);
        end
        @(posedge core_clk);
    endtask

    initial
    begin
        bus_b.addr = 12'h000;
        bus_b.wdata = 8'h00;
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 15; i++)
        begin
            br(rv_addr[i], (i == 0) ? 8'h0c : 8'h00);
        end
        bw(12'h453, 8'h03);
        bw(12'h454, 8'h00);
        bw(12'h455, 8'h1f);
        bw(12'h456, 8'h01);
        bw(12'h457, 8'h0f);
        bw(12'h458, 8'h0f);
        bw(12'h459, 8'h20);
        br(12'h030, 8'h00);
        bw(12'h455, 8'h0f);
        br(12'h030, 8'h04);
        bw(12'h455, 8'h1f);
        bw(12'h458, 8'h4f);
        br(12'h030, 8'h02);
        bw(12'h458, 8'h2f);
        br(12'h458, 8'h2f);
        check(sub_b, 1'b1);
        bw(12'h304, 8'h20);
        br(12'h030, 8'h20);
        bw(12'h304, 8'h0f);
        br(12'h030, 8'h00);
        bw(12'h456, 8'h03);
        br(12'h456, 8'h03);
        br(12'h030, 8'h08);
        check(flg_b, 8'h08);
        bw(12'h454, 8'h01);
        bw(12'h455, 8'h0f);
        br(12'h030, 8'h00);
        bw(12'h300, 8'h08);
        br(12'h030, 8'h08);
        check(dual_b, 1'b1);
        bw(12'h300, 8'hff);
        br(12'h300, 8'h0c);
        bw(12'h46c, 8'h0f);
        br(12'h46c, 8'h0f);
        check(dsk_b, 16'h0f00);
        bw(12'h47d, 8'h03);
        br(12'h47d, 8'h03);
        check(len_b, 16'h0300);
        bw(12'h300, 8'h08);
        bw(12'h46c, 8'hff);
        br(12'h46c, 8'hff);
        check(dsk_b, 16'h0fff);
        bw(12'h300, 8'h00);
        br(12'h300, 8'h00);
        check(dsk_b, 16'h00ff);
        bw(12'h203, 8'hff);
        br(12'h203, 8'h01);
        check(pd_b, 1'b1);
        bw(12'h453, 8'h87);
        br(12'h453, 8'h87);
        check(scr_b, 1'b1);
        bw(12'h459, 8'h00);
        br(12'h459, 8'h00);
        check(ver_b, 1'b0);
        bw(12'h459, 8'h20);
        br(12'h459, 8'h20);
        check(ver_b, 1'b1);
        bw(12'h123, 8'h55);
        br(12'h123, 8'h00);
        for (int d = 0; d < 2; d++)
        begin
            for (int m = 0; m < 16; m++)
            begin
                run(m[3:0], d[0]);
            end
        end
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end
endmodule
